/* File: verilog/lrm_pkg.sv */
`default_nettype none
package lrm_pkg;

  // decoded loop message kinds presented on msg_kind
  typedef enum logic [3:0] {
    LRM_MSG_OTHER       = 4'h0,
    LRM_MSG_LISTEN_ADDR = 4'h1,
    LRM_MSG_TALK_ADDR   = 4'h2,
    LRM_MSG_UNLISTEN    = 4'h3,
    LRM_MSG_UNTALK      = 4'h4,
    LRM_MSG_DEV_LISTEN  = 4'h5,
    LRM_MSG_DEV_TALK    = 4'h6,
    LRM_MSG_SEND_DATA   = 4'h7,
    LRM_MSG_EOT_OK      = 4'h8,
    LRM_MSG_DATA_BYTE   = 4'h9
  } lrm_msg_t;

  // register set selected for a write or read burst
  typedef enum logic [1:0] {
    LRM_SET_NONE = 2'h0,
    LRM_SET_CTRL = 2'h1,
    LRM_SET_CHAR = 2'h2
  } lrm_set_t;

  // read sequencer, gray coded from IDLE through FETCH, LOAD and SEND to EOT
  typedef enum logic [2:0] {
    LRM_RD_IDLE  = 3'h0,
    LRM_RD_FETCH = 3'h1,
    LRM_RD_LOAD  = 3'h3,
    LRM_RD_SEND  = 3'h2,
    LRM_RD_EOT   = 3'h6
  } lrm_rd_state_t;

  localparam int         LRM_N_CTRL     = 14;
  localparam int         LRM_N_CHAR     = 12;
  localparam int         LRM_IDX_W      = 4;
  localparam int         LRM_ADDR_W     = 5;
  localparam logic [4:0] LRM_DD_CTRL    = 5'h00;
  localparam logic [4:0] LRM_DD_CHAR    = 5'h02;
  localparam logic [3:0] LRM_CTRL_RD_HI = 4'h3;
  localparam logic [3:0] LRM_IDX_RST    = 4'h0;
  localparam logic [7:0] LRM_DATA_RST   = 8'h00;

endpackage
`default_nettype wire

/* File: verilog/lrm_rst_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module lrm_rst_sync (
  // clock and raw reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // released reset
  output logic      rst_sync_n
);

  logic meta_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r     <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      meta_r     <= 1'b1;
      rst_sync_n <= meta_r;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/lrm_reg_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module lrm_reg_mem #(
  parameter int WIDTH  = 4,
  parameter int DEPTH  = 14,
  parameter int ADDR_W = 4
) (
  // clock
  input  wire logic              ref_clk,
  // write port
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [WIDTH-1:0]  wdata,
  // read port, one cycle latency
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [WIDTH-1:0]  rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // contents are not reset; software loads them before use
  always_ff @(posedge ref_clk) begin
    if (we && (int'(waddr) < DEPTH)) begin
      mem[waddr] <= wdata;
    end
    if (int'(raddr) < DEPTH) begin
      rdata <= mem[raddr];
    end else begin
      rdata <= '0;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/lrm_msg_access.sv */
// Notes on behaviour
// [RULE_01] device-dependent messages act only in local mode
// [RULE_02] listener message 0 writes control registers
// [RULE_03] listener message 2 writes character registers
// [RULE_04] talker message 0/2 selects read set
// [RULE_05] writes step upward from first register of the selected set
// [RULE_06] control write stores byte value low nibble
// [RULE_07] end-of-transmission ok closes write burst cleanly
// [RULE_08] read waits for send data message
// [RULE_09] read sends one byte per register, nibble low
// [RULE_10] after last register send end-of-transmission ok
// [RULE_11] own talk address makes talker, others untalk
// [RULE_12] own listen address listens, unlisten leaves
// [RULE_13] untalk leaves talker state
// [RULE_14] controller unlistens others before register read
// [RULE_15] surplus write bytes past last register ignored
`timescale 1ns/1ps
`default_nettype none
module lrm_msg_access #(
  parameter int N_CTRL = lrm_pkg::LRM_N_CTRL,
  parameter int N_CHAR = lrm_pkg::LRM_N_CHAR
) (
  // clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            reset_n,
  // device configuration
  input  wire logic                            local_mode,
  input  wire logic [lrm_pkg::LRM_ADDR_W-1:0]  my_addr,
  // decoded incoming loop messages
  input  wire logic                            msg_valid,
  input  wire lrm_pkg::lrm_msg_t               msg_kind,
  input  wire logic [4:0]                      msg_num,
  input  wire logic [7:0]                      msg_data,
  // outgoing data, held until taken or until the talker role is lost
  input  wire logic                            tx_ready,
  output logic                                 tx_valid,
  output logic                                 tx_eot,
  output logic      [7:0]                      tx_data,
  // status
  output logic                                 listener,
  output logic                                 talker,
  output logic                                 wr_done
);

  localparam int IW = lrm_pkg::LRM_IDX_W;

  logic                   rst_n;
  logic                   listen_r;
  logic                   listen_nxt;
  logic                   talk_r;
  logic                   talk_nxt;
  lrm_pkg::lrm_set_t      wsel_r;
  lrm_pkg::lrm_set_t      wsel_nxt;
  logic [IW-1:0]          widx_r;
  logic [IW-1:0]          widx_nxt;
  logic                   wfull_r;
  logic                   wfull_nxt;
  logic                   done_r;
  logic                   done_nxt;
  lrm_pkg::lrm_set_t      rsel_r;
  lrm_pkg::lrm_set_t      rsel_nxt;
  lrm_pkg::lrm_rd_state_t rst_r;
  lrm_pkg::lrm_rd_state_t rst_nxt;
  logic [IW-1:0]          ridx_r;
  logic [IW-1:0]          ridx_nxt;
  logic                   txv_r;
  logic                   txv_nxt;
  logic                   txe_r;
  logic                   txe_nxt;
  logic [7:0]             txd_r;
  logic [7:0]             txd_nxt;
  logic                   ctrl_we;
  logic                   char_we;
  logic [3:0]             ctrl_rdata;
  logic [7:0]             char_rdata;

  // index of the last register of a set
  function automatic logic [IW-1:0] last_idx(input lrm_pkg::lrm_set_t s);
    if (s == lrm_pkg::LRM_SET_CTRL) begin
      last_idx = IW'(N_CTRL - 1);
    end else begin
      last_idx = IW'(N_CHAR - 1);
    end
  endfunction

  // secondary number to register set
  function automatic lrm_pkg::lrm_set_t num_to_set(input logic [4:0] n);
    if (n == lrm_pkg::LRM_DD_CTRL) begin
      num_to_set = lrm_pkg::LRM_SET_CTRL;
    end else if (n == lrm_pkg::LRM_DD_CHAR) begin
      num_to_set = lrm_pkg::LRM_SET_CHAR;
    end else begin
      num_to_set = lrm_pkg::LRM_SET_NONE;
    end
  endfunction

  lrm_rst_sync u_rst_sync (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .rst_sync_n (rst_n)
  );

  lrm_reg_mem #(
    .WIDTH  (4),
    .DEPTH  (N_CTRL),
    .ADDR_W (IW)
  ) u_ctrl_mem (
    .ref_clk (ref_clk),
    .we      (ctrl_we),
    .waddr   (widx_r),
    .wdata   (msg_data[3:0]), // RULE_06
    .raddr   (ridx_r),
    .rdata   (ctrl_rdata)
  );

  lrm_reg_mem #(
    .WIDTH  (8),
    .DEPTH  (N_CHAR),
    .ADDR_W (IW)
  ) u_char_mem (
    .ref_clk (ref_clk),
    .we      (char_we),
    .waddr   (widx_r),
    .wdata   (msg_data),
    .raddr   (ridx_r),
    .rdata   (char_rdata)
  );

  logic is_msg_data;
  assign is_msg_data = msg_valid && (msg_kind == lrm_pkg::LRM_MSG_DATA_BYTE);

  // a data byte lands only in an open, unfilled burst
  logic wr_take;
  assign wr_take = is_msg_data && listen_r && local_mode &&
                   (wsel_r != lrm_pkg::LRM_SET_NONE) && !wfull_r; // RULE_01 RULE_15
  assign ctrl_we = wr_take && (wsel_r == lrm_pkg::LRM_SET_CTRL);  // RULE_02
  assign char_we = wr_take && (wsel_r == lrm_pkg::LRM_SET_CHAR);  // RULE_03

  // addressing and write side
  always_comb begin
    listen_nxt = listen_r;
    talk_nxt   = talk_r;
    wsel_nxt   = wsel_r;
    widx_nxt   = widx_r;
    wfull_nxt  = wfull_r;
    done_nxt   = 1'b0;
    rsel_nxt   = rsel_r;
    if (msg_valid) begin
      case (msg_kind)
        lrm_pkg::LRM_MSG_LISTEN_ADDR: begin
          if (msg_num == my_addr) begin
            listen_nxt = 1'b1; // RULE_12
          end
        end
        lrm_pkg::LRM_MSG_TALK_ADDR: begin
          // another device's talk address takes the talker role away
          talk_nxt = (msg_num == my_addr); // RULE_11
          rsel_nxt = lrm_pkg::LRM_SET_NONE;
        end
        lrm_pkg::LRM_MSG_UNLISTEN: begin
          listen_nxt = 1'b0; // RULE_12
          wsel_nxt   = lrm_pkg::LRM_SET_NONE;
        end
        lrm_pkg::LRM_MSG_UNTALK: begin
          talk_nxt = 1'b0; // RULE_13
          rsel_nxt = lrm_pkg::LRM_SET_NONE;
        end
        lrm_pkg::LRM_MSG_DEV_LISTEN: begin
          if (listen_r && local_mode) begin // RULE_01
            wsel_nxt  = num_to_set(msg_num); // RULE_02 RULE_03
            widx_nxt  = lrm_pkg::LRM_IDX_RST; // RULE_05
            wfull_nxt = 1'b0;
          end
        end
        lrm_pkg::LRM_MSG_DEV_TALK: begin
          if (talk_r && local_mode) begin // RULE_01
            rsel_nxt = num_to_set(msg_num); // RULE_04
          end
        end
        lrm_pkg::LRM_MSG_EOT_OK: begin
          if (listen_r && (wsel_r != lrm_pkg::LRM_SET_NONE)) begin
            done_nxt = 1'b1; // RULE_07
            wsel_nxt = lrm_pkg::LRM_SET_NONE;
          end
        end
        lrm_pkg::LRM_MSG_DATA_BYTE: begin
          if (wr_take) begin
            if (widx_r == last_idx(wsel_r)) begin
              wfull_nxt = 1'b1; // RULE_15
            end else begin
              widx_nxt = widx_r + IW'(1); // RULE_05
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      listen_r <= 1'b0;
      talk_r   <= 1'b0;
      wsel_r   <= lrm_pkg::LRM_SET_NONE;
      widx_r   <= lrm_pkg::LRM_IDX_RST;
      wfull_r  <= 1'b0;
      done_r   <= 1'b0;
      rsel_r   <= lrm_pkg::LRM_SET_NONE;
    end else begin
      listen_r <= listen_nxt;
      talk_r   <= talk_nxt;
      wsel_r   <= wsel_nxt;
      widx_r   <= widx_nxt;
      wfull_r  <= wfull_nxt;
      done_r   <= done_nxt;
      rsel_r   <= rsel_nxt;
    end
  end

  // read sequencer; memory read data lag the index by one cycle,
  // hence the fetch state ahead of each load
  always_comb begin
    rst_nxt  = rst_r;
    ridx_nxt = ridx_r;
    txv_nxt  = txv_r;
    txe_nxt  = txe_r;
    txd_nxt  = txd_r;
    case (rst_r)
      lrm_pkg::LRM_RD_IDLE: begin
        if (msg_valid && (msg_kind == lrm_pkg::LRM_MSG_SEND_DATA) && talk_r &&
            (rsel_r != lrm_pkg::LRM_SET_NONE)) begin
          rst_nxt  = lrm_pkg::LRM_RD_FETCH; // RULE_08
          ridx_nxt = lrm_pkg::LRM_IDX_RST;
        end
      end
      lrm_pkg::LRM_RD_FETCH: begin
        rst_nxt = lrm_pkg::LRM_RD_LOAD;
      end
      lrm_pkg::LRM_RD_LOAD: begin
        rst_nxt = lrm_pkg::LRM_RD_SEND;
        txv_nxt = 1'b1;
        txe_nxt = 1'b0;
        if (rsel_r == lrm_pkg::LRM_SET_CTRL) begin
          txd_nxt = {lrm_pkg::LRM_CTRL_RD_HI, ctrl_rdata}; // RULE_09
        end else begin
          txd_nxt = char_rdata;
        end
      end
      lrm_pkg::LRM_RD_SEND: begin
        if (tx_ready) begin
          if (ridx_r == last_idx(rsel_r)) begin
            rst_nxt = lrm_pkg::LRM_RD_EOT; // RULE_10
            txe_nxt = 1'b1;
            txd_nxt = lrm_pkg::LRM_DATA_RST;
          end else begin
            rst_nxt  = lrm_pkg::LRM_RD_FETCH; // RULE_09
            ridx_nxt = ridx_r + IW'(1);
            txv_nxt  = 1'b0;
          end
        end
      end
      lrm_pkg::LRM_RD_EOT: begin
        if (tx_ready) begin
          rst_nxt = lrm_pkg::LRM_RD_IDLE;
          txv_nxt = 1'b0;
          txe_nxt = 1'b0;
        end
      end
      default: begin
        rst_nxt = lrm_pkg::LRM_RD_IDLE;
        txv_nxt = 1'b0;
        txe_nxt = 1'b0;
      end
    endcase
    // losing the talker role cuts a read short, even mid-byte
    if (!talk_nxt) begin
      rst_nxt = lrm_pkg::LRM_RD_IDLE; // RULE_13
      txv_nxt = 1'b0;
      txe_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_r  <= lrm_pkg::LRM_RD_IDLE;
      ridx_r <= lrm_pkg::LRM_IDX_RST;
      txv_r  <= 1'b0;
      txe_r  <= 1'b0;
      txd_r  <= lrm_pkg::LRM_DATA_RST;
    end else begin
      rst_r  <= rst_nxt;
      ridx_r <= ridx_nxt;
      txv_r  <= txv_nxt;
      txe_r  <= txe_nxt;
      txd_r  <= txd_nxt;
    end
  end

  assign tx_valid = txv_r;
  assign tx_eot   = txe_r;
  assign tx_data  = txd_r;
  assign listener = listen_r;
  assign talker   = talk_r;
  assign wr_done  = done_r;

endmodule
`default_nettype wire

/* File: dv/lrm_msg_access_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module lrm_msg_access_monitor #(
  parameter int N_CTRL = 14,
  parameter int N_CHAR = 12
) (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              reset_n,
  // configuration
  input wire logic              local_mode,
  input wire logic [4:0]        my_addr,
  // incoming messages
  input wire logic              msg_valid,
  input wire lrm_pkg::lrm_msg_t msg_kind,
  input wire logic [4:0]        msg_num,
  input wire logic [7:0]        msg_data,
  // outgoing items
  input wire logic              tx_ready,
  input wire logic              tx_valid,
  input wire logic              tx_eot,
  input wire logic [7:0]        tx_data,
  // status
  input wire logic              listener,
  input wire logic              talker,
  input wire logic              wr_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] k;
  logic       sd_w;
  logic       tk_w;
  logic       eot_w;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  // kind reads as zero when no message is offered
  assign k = msg_valid ? msg_kind : 4'h0;
  assign sd_w = k == lrm_pkg::LRM_MSG_SEND_DATA;
  assign eot_w = k == lrm_pkg::LRM_MSG_EOT_OK;
  assign tk_w = tx_valid && tx_ready;
  // register bytes taken since the last start of a read
  always_comb begin
    cnt_nxt = cnt_r;
    if (sd_w) cnt_nxt = 5'h00;
    else if (tk_w && !tx_eot) cnt_nxt = cnt_r + 5'h01;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) cnt_r <= 5'h00;
    else cnt_r <= cnt_nxt;
  end
  a_listen_enter: assert property (k == lrm_pkg::LRM_MSG_LISTEN_ADDR && msg_num == my_addr
    |=> listener) else $error("listener not entered");
  a_unlisten_leave: assert property (k == lrm_pkg::LRM_MSG_UNLISTEN |=> !listener)
    else $error("listener not left");
  a_talk_enter: assert property (k == lrm_pkg::LRM_MSG_TALK_ADDR && msg_num == my_addr
    |=> talker) else $error("talker not entered");
  a_talk_yield: assert property (k == lrm_pkg::LRM_MSG_TALK_ADDR && msg_num != my_addr
    |=> !talker) else $error("talker kept for other address");
  a_untalk_leave: assert property (k == lrm_pkg::LRM_MSG_UNTALK |=> !talker)
    else $error("talker not left");
  a_wr_done_cause: assert property (wr_done |-> $past(eot_w))
    else $error("write done without end message");
  a_tx_item_hold: assert property (tx_valid && !tx_ready && talker
    && k != lrm_pkg::LRM_MSG_UNTALK && k != lrm_pkg::LRM_MSG_TALK_ADDR
    |=> tx_valid && $stable(tx_data) && $stable(tx_eot)) else $error("item not held");
  a_tx_wait_send: assert property ($rose(tx_valid) && !tx_eot
    |-> $past(sd_w, 3) || $past(tk_w, 3)) else $error("byte offered unasked");
  a_eot_after_last: assert property (tx_valid && tx_eot
    |-> tx_data == 8'h00 && (cnt_r == N_CTRL || cnt_r == N_CHAR)) else $error("early end");
endmodule
bind lrm_msg_access lrm_msg_access_monitor #(.N_CTRL(N_CTRL), .N_CHAR(N_CHAR)) i_mon (
  .ref_clk(ref_clk), .reset_n(reset_n), .local_mode(local_mode), .my_addr(my_addr),
  .msg_valid(msg_valid), .msg_kind(msg_kind), .msg_num(msg_num), .msg_data(msg_data),
  .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_eot(tx_eot), .tx_data(tx_data),
  .listener(listener), .talker(talker), .wr_done(wr_done));
`default_nettype wire

/* File: dv/lrm_loop_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lrm_loop_ctrl_model (
  // clock and offered item
  input  wire logic ref_clk,
  input  wire logic tx_valid,
  // cycles to stall before taking
  input  var  int   stall,
  // take strobe
  output logic      tx_ready
);
  int   wt;
  logic tk;
  initial tx_ready = 1'b0;
  initial wt = 0;
  // ready is held until the edge that takes the item
  always @(posedge ref_clk) begin
    tk = tx_valid && tx_ready;
    #1;
    if (tk || !tx_valid) begin
      tx_ready = 1'b0;
      wt = 0;
    end else if (wt >= stall) tx_ready = 1'b1;
    else wt++;
  end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic              ref_clk, reset_n, local_mode, msg_valid, tx_ready, tx_valid, tx_eot;
  logic              listener, talker, wr_done;
  lrm_pkg::lrm_msg_t msg_kind;
  logic [4:0]        my_addr, msg_num;
  logic [7:0]        msg_data, tx_data;
  logic [3:0]        ctrl_m [14];
  logic [7:0]        char_m [12];
  int                mismatches, checked, stall;
  lrm_msg_access i_lrm_msg_access (.ref_clk(ref_clk), .reset_n(reset_n),
    .local_mode(local_mode), .my_addr(my_addr), .msg_valid(msg_valid), .msg_kind(msg_kind),
    .msg_num(msg_num), .msg_data(msg_data), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_eot(tx_eot), .tx_data(tx_data), .listener(listener), .talker(talker),
    .wr_done(wr_done));
  lrm_loop_ctrl_model i_lrm_loop_ctrl_model (.ref_clk(ref_clk), .tx_valid(tx_valid),
    .stall(stall), .tx_ready(tx_ready));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic msg(input lrm_pkg::lrm_msg_t k, input logic [4:0] n, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    msg_valid = 1'b1;
    msg_kind = k;
    msg_num = n;
    msg_data = d;
    @(posedge ref_clk);
    #1;
    msg_valid = 1'b0;
  endtask
  // one byte beyond the set is sent to probe the overflow guard
  task automatic wr(input logic [4:0] set, input int n, input logic [7:0] base);
    int i;
    msg(lrm_pkg::LRM_MSG_UNLISTEN, 5'h00, 8'h00);
    msg(lrm_pkg::LRM_MSG_LISTEN_ADDR, 5'h03, 8'h00);
    chk({8'h00, listener}, 9'h001);
    msg(lrm_pkg::LRM_MSG_DEV_LISTEN, set, 8'h00);
    for (i = 0; i <= n; i++) msg(lrm_pkg::LRM_MSG_DATA_BYTE, 5'h00, base + 8'(i));
    msg(lrm_pkg::LRM_MSG_EOT_OK, 5'h00, 8'h00);
    chk({8'h00, wr_done}, {8'h00, local_mode});
    msg(lrm_pkg::LRM_MSG_UNLISTEN, 5'h00, 8'h00);
    chk({8'h00, listener}, 9'h000);
  endtask
  task automatic rd(input logic [4:0] set, input int n);
    int i, w;
    msg(lrm_pkg::LRM_MSG_UNLISTEN, 5'h00, 8'h00);
    msg(lrm_pkg::LRM_MSG_TALK_ADDR, 5'h03, 8'h00);
    chk({8'h00, talker}, 9'h001);
    msg(lrm_pkg::LRM_MSG_DEV_TALK, set, 8'h00);
    msg(lrm_pkg::LRM_MSG_SEND_DATA, 5'h00, 8'h00);
    // judge at the falling edge, where item and take strobe are settled
    for (i = 0; i <= n; i++) begin
      w = 0;
      do begin
        @(negedge ref_clk);
        w++;
      end while ((tx_valid & tx_ready) !== 1'b1 && w < 40);
      chk({8'h00, tx_valid & tx_ready}, 9'h001);
      if (i == n) chk({tx_eot, tx_data}, 9'h100);
      else if (set == 5'h00) chk({tx_eot, tx_data}, {5'h03, ctrl_m[i]});
      else chk({tx_eot, tx_data}, {1'b0, char_m[i]});
      @(posedge ref_clk);
    end
    msg(lrm_pkg::LRM_MSG_UNTALK, 5'h00, 8'h00);
    chk({8'h00, talker}, 9'h000);
  endtask
  task automatic t_ctrl;
    int i;
    stall = 0;
    for (i = 0; i < 14; i++) ctrl_m[i] = 4'(i + 2);
    wr(5'h00, 14, 8'h02);
    rd(5'h00, 14);
  endtask
  task automatic t_char;
    int i;
    stall = 4;
    for (i = 0; i < 12; i++) char_m[i] = 8'hA0 + 8'(i);
    wr(5'h02, 12, 8'hA0);
    rd(5'h02, 12);
  endtask
  // remote mode must leave the control set untouched
  task automatic t_remote;
    local_mode = 1'b0;
    wr(5'h00, 14, 8'h00);
    msg(lrm_pkg::LRM_MSG_TALK_ADDR, 5'h03, 8'h00);
    msg(lrm_pkg::LRM_MSG_DEV_TALK, 5'h00, 8'h00);
    msg(lrm_pkg::LRM_MSG_SEND_DATA, 5'h00, 8'h00);
    repeat (6) @(negedge ref_clk);
    chk({8'h00, tx_valid}, 9'h000);
    @(posedge ref_clk);
    #1;
    local_mode = 1'b1;
    rd(5'h00, 14);
  endtask
  task automatic t_talk;
    msg(lrm_pkg::LRM_MSG_TALK_ADDR, 5'h03, 8'h00);
    chk({8'h00, talker}, 9'h001);
    msg(lrm_pkg::LRM_MSG_TALK_ADDR, 5'h07, 8'h00);
    chk({8'h00, talker}, 9'h000);
  endtask
  task automatic complete_run;
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    complete_run;
  end
  initial begin
    reset_n = 1'b0;
    local_mode = 1'b1;
    my_addr = 5'h03;
    msg_valid = 1'b0;
    msg_kind = lrm_pkg::LRM_MSG_OTHER;
    msg_num = 5'h00;
    msg_data = 8'h00;
    stall = 0;
    mismatches = 0;
    checked = 0;
    repeat (3) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    t_ctrl;
    t_char;
    t_remote;
    t_talk;
    complete_run;
  end
endmodule
`default_nettype wire
